// ==== src/irqf_regs.svh ====
/*
 * Register offsets, field positions, reset values and command codes for
 * the interrupt request flag block.
 * Assumes an 8-bit register port with byte offsets as printed.
 */
`ifndef IRQF_REGS_SVH
`define IRQF_REGS_SVH

// register offsets
`define IRQF_OFS_REQ_A 8'h06
`define IRQF_OFS_REQ_B 8'h07
`define IRQF_OFS_EN_A 8'h08
`define IRQF_OFS_EN_B 8'h09

// request register fields
`define IRQF_BIT_SET_DIR 7
`define IRQF_BIT_GLOBAL 6
`define IRQF_REQ_A_FLAGS 7
`define IRQF_REQ_B_FLAGS 6

// enable register fields
`define IRQF_BIT_INVERT 7
`define IRQF_BIT_PIN_EN 6
`define IRQF_BIT_PUSH_PULL 7

// reset values
`define IRQF_RST_REQ_A 7'h00
`define IRQF_RST_REQ_B 6'h00
`define IRQF_RST_EN 8'h00
`define IRQF_RST_RDATA 8'h00

// command field
`define IRQF_CMD_W 4
`define IRQF_CMD_IDLE 4'h0
`define IRQF_CMD_KNOWN 16'hFFFF

`endif

// ==== src/irqf_pkg.sv ====
/*
 * Types shared by the interrupt request flag block.
 * Assumes the constants header is compiled alongside.
 */
package irqf_pkg;

    // register port request from the host serial interface
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } irqf_reg_req_t;

    // error conditions feeding the error flag
    typedef struct packed {
        logic forbidden_write_error;
        logic fifo_overflow_error;
        logic protocol_error;
        logic empty_send_error;
        logic integrity_error;
    } irqf_err_t;

    // event sources of the block
    typedef struct packed {
        logic fifo_high_status;
        logic fifo_low_status;
        logic tx_last_bit;
        logic rx_end;
        logic rx_sof;
        logic card_found;
        logic [4:0] timer_underflow;
    } irqf_evt_t;

    // interrupt pin as value plus output enable
    typedef struct packed {
        logic out;
        logic oe;
    } irqf_pin_t;

endpackage

// ==== src/irqf_flag_bank.sv ====
/*
 * Bank of sticky request flags with a write-one set/clear port.
 * Assumes hardware events and software writes arrive synchronous.
 */
`timescale 1ns/100ps
module irqf_flag_bank #(
    parameter int WIDTH = 7,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // software access
    input wire logic wr_i,
    input wire logic set_dir_i,
    input wire logic [WIDTH-1:0] sel_i,
    // hardware events
    input wire logic [WIDTH-1:0] event_i,
    // stored flags
    output logic [WIDTH-1:0] flags_o
);

    logic [WIDTH-1:0] flags_q;
    logic [WIDTH-1:0] sw_set;
    logic [WIDTH-1:0] sw_clr;

    // zeros written leave flags alone
    assign sw_set = (wr_i && set_dir_i) ? sel_i : '0;
    assign sw_clr = (wr_i && !set_dir_i) ? sel_i : '0;

    // set beats clear so an event in the clear cycle survives
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            flags_q <= RESET_VAL;
        end else if (ce_i) begin
            flags_q <= (flags_q & ~sw_clr) | sw_set | event_i;
        end
    end

    assign flags_o = flags_q;

endmodule

// ==== src/irqf_cmd_watch.sv ====
/*
 * Command field keeper: spots commands that end, so the done flag fires.
 * Assumes the sequencer pulses end_i when a command finishes by itself.
 */
`timescale 1ns/100ps
`include "irqf_regs.svh"
module irqf_cmd_watch #(
    parameter logic [15:0] KNOWN_MASK = `IRQF_CMD_KNOWN
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // host writes to the command field
    input wire logic wr_i,
    input wire logic [`IRQF_CMD_W-1:0] code_i,
    // sequencer reports completion
    input wire logic end_i,
    // field and done event
    output logic [`IRQF_CMD_W-1:0] command_o,
    output logic done_o
);

    logic [`IRQF_CMD_W-1:0] command_q;
    logic done_q;
    logic known;

    assign known = KNOWN_MASK[code_i];

    // host write has priority over a finish in the same cycle
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            command_q <= `IRQF_CMD_IDLE;
            done_q <= 1'b0;
        end else if (ce_i) begin
            done_q <= 1'b0;
            if (wr_i) begin
                if (code_i == `IRQF_CMD_IDLE) begin
                    command_q <= `IRQF_CMD_IDLE;
                end else if (!known) begin
                    command_q <= `IRQF_CMD_IDLE;
                    done_q <= 1'b1;
                end else begin
                    command_q <= code_i;
                end
            end else if (end_i && command_q != `IRQF_CMD_IDLE) begin
                command_q <= `IRQF_CMD_IDLE;
                done_q <= 1'b1;
            end
        end
    end

    assign command_o = command_q;
    assign done_o = done_q;

endmodule

// ==== src/irqf_top.sv ====
/*
 * Interrupt request flag block: two request registers, two enable
 * registers, global request and interrupt pin driver.
 * Assumes all inputs are synchronous to clock_i and that the register
 * port is the host serial interface's decoded byte access.
 */
`timescale 1ns/100ps
`include "irqf_regs.svh"
module irqf_top #(
    parameter logic [15:0] CMD_KNOWN_MASK = `IRQF_CMD_KNOWN
) (
    // clock, reset, enable
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // register port
    input wire irqf_pkg::irqf_reg_req_t reg_req_i,
    output logic [7:0] reg_rdata_o,
    // event sources
    input wire irqf_pkg::irqf_evt_t evt_i,
    input wire irqf_pkg::irqf_err_t err_i,
    // command field
    input wire logic cmd_wr_i,
    input wire logic [`IRQF_CMD_W-1:0] cmd_code_i,
    input wire logic cmd_end_i,
    output logic [`IRQF_CMD_W-1:0] command_o,
    // interrupt pin
    output irqf_pkg::irqf_pin_t irq_pin_o,
    output logic global_request_o
);

    // register state
    logic [7:0] enable_a_q;
    logic [7:0] enable_b_q;
    logic global_request_q;
    logic [7:0] rdata_q;
    irqf_pkg::irqf_pin_t pin_q;

    // edge detect history for level sources
    logic fifo_high_prev_q;
    logic fifo_low_prev_q;
    irqf_pkg::irqf_err_t err_prev_q;

    // flag banks and their controls
    logic [`IRQF_REQ_A_FLAGS-1:0] flags_a;
    logic [`IRQF_REQ_B_FLAGS-1:0] flags_b;
    logic [`IRQF_REQ_A_FLAGS-1:0] events_a;
    logic [`IRQF_REQ_B_FLAGS-1:0] events_b;
    logic wr_req_a;
    logic wr_req_b;
    logic set_dir;

    // command tracking
    logic [`IRQF_CMD_W-1:0] command;
    logic command_done;

    // derived events
    logic high_rise;
    logic low_rise;
    logic err_rise;
    logic global_d;
    logic pin_active;
    logic pin_level;

    // write decodes
    assign wr_req_a = reg_req_i.wr && (reg_req_i.addr == `IRQF_OFS_REQ_A);
    assign wr_req_b = reg_req_i.wr && (reg_req_i.addr == `IRQF_OFS_REQ_B);
    assign set_dir = reg_req_i.wdata[`IRQF_BIT_SET_DIR];

    // command field tracking lives in its own module
    irqf_cmd_watch #(
        .KNOWN_MASK(CMD_KNOWN_MASK)
    ) u_cmd_watch (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .wr_i(cmd_wr_i),
        .code_i(cmd_code_i),
        .end_i(cmd_end_i),
        .command_o(command),
        .done_o(command_done)
    );

    // history for rising edge detection; a held status must not keep
    // re-arming the flag after software clears it
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            fifo_high_prev_q <= 1'b0;
            fifo_low_prev_q <= 1'b0;
            err_prev_q <= '0;
        end else if (ce_i) begin
            fifo_high_prev_q <= evt_i.fifo_high_status;
            fifo_low_prev_q <= evt_i.fifo_low_status;
            err_prev_q <= err_i;
        end
    end

    // event edges
    assign high_rise = evt_i.fifo_high_status && !fifo_high_prev_q;
    assign low_rise = evt_i.fifo_low_status && !fifo_low_prev_q;
    assign err_rise = |(err_i & ~err_prev_q);

    // hardware events for request A, ordered by bit position
    assign events_a = {
        high_rise,
        low_rise,
        command_done,
        evt_i.tx_last_bit,
        evt_i.rx_end,
        err_rise,
        evt_i.rx_sof
    };

    // hardware events for request B
    assign events_b = {
        evt_i.card_found,
        evt_i.timer_underflow
    };

    // request A flags; zero after reset
    irqf_flag_bank #(
        .WIDTH(`IRQF_REQ_A_FLAGS),
        .RESET_VAL(`IRQF_RST_REQ_A)
    ) u_flags_a (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .wr_i(wr_req_a),
        .set_dir_i(set_dir),
        .sel_i(reg_req_i.wdata[`IRQF_REQ_A_FLAGS-1:0]),
        .event_i(events_a),
        .flags_o(flags_a)
    );

    // request B flags; bit 6 is the computed global request, not stored
    irqf_flag_bank #(
        .WIDTH(`IRQF_REQ_B_FLAGS),
        .RESET_VAL(`IRQF_RST_REQ_B)
    ) u_flags_b (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .wr_i(wr_req_b),
        .set_dir_i(set_dir),
        .sel_i(reg_req_i.wdata[`IRQF_REQ_B_FLAGS-1:0]),
        .event_i(events_b),
        .flags_o(flags_b)
    );

    // enable registers are plain read/write
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            enable_a_q <= `IRQF_RST_EN;
            enable_b_q <= `IRQF_RST_EN;
        end else if (ce_i && reg_req_i.wr) begin
            if (reg_req_i.addr == `IRQF_OFS_EN_A) begin
                enable_a_q <= reg_req_i.wdata;
            end
            if (reg_req_i.addr == `IRQF_OFS_EN_B) begin
                enable_b_q <= reg_req_i.wdata;
            end
        end
    end

    // global request: or of enabled flags, rebuilt every cycle so it
    // falls once every source is cleared or masked
    assign global_d = |(flags_a & enable_a_q[`IRQF_REQ_A_FLAGS-1:0])
        | |(flags_b & enable_b_q[`IRQF_REQ_B_FLAGS-1:0]);

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            global_request_q <= 1'b0;
        end else if (ce_i) begin
            global_request_q <= global_d;
        end
    end

    // pin level: active only when the pin is enabled, then inverted when the invert bit is set
    assign pin_active = global_request_q && enable_b_q[`IRQF_BIT_PIN_EN];
    assign pin_level = pin_active ^ enable_a_q[`IRQF_BIT_INVERT];

    // pin driver; open drain only ever pulls low, the line floats high
    // through the board pull-up otherwise
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            pin_q.out <= 1'b0;
            pin_q.oe <= 1'b0;
        end else if (ce_i) begin
            if (enable_b_q[`IRQF_BIT_PUSH_PULL]) begin
                pin_q.out <= pin_level;
                pin_q.oe <= 1'b1;
            end else begin
                pin_q.out <= 1'b0;
                pin_q.oe <= !pin_level;
            end
        end
    end

    // read data, one cycle after the strobe; unmapped offsets read zero
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            rdata_q <= `IRQF_RST_RDATA;
        end else if (ce_i && reg_req_i.rd) begin
            unique case (reg_req_i.addr)
                `IRQF_OFS_REQ_A: rdata_q <= {1'b0, flags_a};
                `IRQF_OFS_REQ_B: rdata_q <= {1'b0, global_request_q, flags_b};
                `IRQF_OFS_EN_A: rdata_q <= enable_a_q;
                `IRQF_OFS_EN_B: rdata_q <= enable_b_q;
                default: rdata_q <= `IRQF_RST_RDATA;
            endcase
        end
    end

    // outputs straight from flops
    assign reg_rdata_o = rdata_q;
    assign irq_pin_o = pin_q;
    assign global_request_o = global_request_q;
    assign command_o = command;

endmodule

// ==== verification/irqf_props.sv ====
/* port assertions for the flag block.
   assumes a bind from the bench and one clock. */
`timescale 1ns/100ps
`include "irqf_regs.svh"
module irqf_props #(
    parameter logic [15:0] CMD_KNOWN_MASK = 16'hFFFF
) (
    // watched ports
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire irqf_pkg::irqf_reg_req_t reg_req_i,
    input wire logic [7:0] reg_rdata_o,
    input wire irqf_pkg::irqf_evt_t evt_i,
    input wire irqf_pkg::irqf_err_t err_i,
    input wire logic cmd_wr_i,
    input wire logic [`IRQF_CMD_W-1:0] cmd_code_i,
    input wire logic cmd_end_i,
    input wire logic [`IRQF_CMD_W-1:0] command_o,
    input wire irqf_pkg::irqf_pin_t irq_pin_o,
    input wire logic global_request_o
);
    logic [7:0] en_a_q;
    logic [7:0] en_b_q;
    logic en_wr;
    // enables are shadowed; checks skip the edge that writes them
    assign en_wr = ce_i && reg_req_i.wr && reg_req_i.addr[7:1] == 7'h04;
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            en_a_q <= 8'h00;
            en_b_q <= 8'h00;
        end else if (en_wr && !reg_req_i.addr[0]) begin
            en_a_q <= reg_req_i.wdata;
        end else if (en_wr) begin
            en_b_q <= reg_req_i.wdata;
        end
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    pin_push_a: assert property (
        ce_i && en_b_q[7] && !en_wr |=> irq_pin_o.oe &&
        irq_pin_o.out == (($past(global_request_o) & en_b_q[6]) ^ en_a_q[7]))
        else $error("push-pull pin wrong");
    pin_drain_a: assert property (
        ce_i && !en_b_q[7] && !en_wr |=> !irq_pin_o.out &&
        irq_pin_o.oe == !(($past(global_request_o) & en_b_q[6]) ^ en_a_q[7]))
        else $error("open-drain pin wrong");
    dir_bit_a: assert property (
        ce_i && reg_req_i.rd && reg_req_i.addr[7:1] == 7'h03 |=> !reg_rdata_o[7])
        else $error("direction bit read back");
    rx_global_a: assert property (
        ce_i && !en_wr && evt_i.rx_end && en_a_q[2] ##1 ce_i |=> global_request_o)
        else $error("receive event missed global");
    timer_global_a: assert property (
        ce_i && !en_wr && evt_i.timer_underflow[0] && en_b_q[0] ##1 ce_i
        |=> global_request_o) else $error("timer event missed global");
    err_global_a: assert property (
        ce_i && $past(ce_i) && !en_wr && en_a_q[1] && err_i != '0 && $past(err_i) == '0
        ##1 ce_i
        |=> global_request_o) else $error("error event missed global");
    cmd_unknown_a: assert property (
        ce_i && cmd_wr_i && !CMD_KNOWN_MASK[cmd_code_i] |-> ##[1:2] command_o == 4'h0)
        else $error("unknown command kept");
    done_global_a: assert property (
        ce_i && !en_wr && en_a_q[4] && cmd_end_i && !cmd_wr_i && command_o != 4'h0
        ##1 (ce_i && !en_wr) [*2] |=> global_request_o)
        else $error("command end missed global");
endmodule

// ==== verification/irqf_host_model.sv ====
/* host-side view of the interrupt line.
   assumes a board pull-up on the line. */
`timescale 1ns/100ps
module irqf_host_model (
    // pin from the block
    input wire irqf_pkg::irqf_pin_t pin_i,
    // level the host sees
    output logic line_o
);
    // a released line floats to the pull-up, never keeps the old value
    assign line_o = pin_i.oe ? pin_i.out : 1'b1;
endmodule

// ==== verification/irqf_top_test.sv ====
/* self-checking bench: register tasks, event pulses, read notes in a queue.
   assumes the host model resolves the interrupt line. */
`timescale 1ns/100ps
module irqf_top_test;
    localparam logic [7:0] AMAP [5] = '{8'h01, 8'h04, 8'h08, 8'h20, 8'h40};
    localparam logic [7:0] PA [6] = '{8'h10, 8'h10, 8'h90, 8'h10, 8'h90, 8'h10};
    localparam logic [7:0] PB [6] = '{8'h40, 8'hC0, 8'hC0, 8'h80, 8'h00, 8'h00};
    localparam logic [5:0] PL = 6'b010011;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic ce_i = 1'b1;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    irqf_pkg::irqf_reg_req_t reg_req_i;
    irqf_pkg::irqf_evt_t evt_i = '0;
    irqf_pkg::irqf_err_t err_i = '0;
    logic cmd_wr_i = 1'b0;
    logic cmd_end_i = 1'b0;
    logic [3:0] cmd_code_i = 4'h0;
    logic [7:0] reg_rdata_o;
    logic [3:0] command_o;
    irqf_pkg::irqf_pin_t irq_pin_o;
    logic global_request_o;
    logic line;
    logic rd_q = 1'b0;
    logic [7:0] expq [$];
    logic [7:0] ex;
    logic [7:0] v;
    int err_count = 0;
    int checks = 0;
    int cyc = 0;
    int i;
    assign reg_req_i = {wr_s, rd_s, addr, wdata};
    // code 7 is marked unknown so the idle fallback is reachable
    irqf_top #(.CMD_KNOWN_MASK(16'hFF7F)) DUT (.*);
    irqf_host_model host (.pin_i(irq_pin_o), .line_o(line));
    always #5 clock_i = ~clock_i;
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checks++;
        if (seen !== want) begin
            err_count++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic final_report();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // strobes stay up until tick, so back-to-back accesses never glitch
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wr_s = 1'b1;
        rd_s = 1'b0;
        addr = a;
        wdata = d;
        @(negedge clock_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] want);
        rd_s = 1'b1;
        wr_s = 1'b0;
        addr = a;
        expq.push_back(want);
        @(negedge clock_i);
    endtask
    task automatic tick(input int n);
        wr_s = 1'b0;
        rd_s = 1'b0;
        cmd_wr_i = 1'b0;
        cmd_end_i = 1'b0;
        repeat (n) @(negedge clock_i);
    endtask
    task automatic pulse(input logic [10:0] e, input logic [4:0] r);
        evt_i = irqf_pkg::irqf_evt_t'(e);
        err_i = irqf_pkg::irqf_err_t'(r);
        @(negedge clock_i);
        evt_i = '0;
        err_i = '0;
    endtask
    task automatic cmd(input logic w, input logic [3:0] c, input logic e);
        cmd_wr_i = w;
        cmd_code_i = c;
        cmd_end_i = e;
        @(negedge clock_i);
    endtask
    // read data lands one edge after the strobe; pop the oldest note
    always @(posedge clock_i) rd_q <= rd_s && ce_i && !reset_i;
    always @(negedge clock_i) begin
        if (rd_q) begin
            check(reg_rdata_o, expq.pop_front());
        end
    end
    // the tests need well under a thousand cycles
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 4000) begin
            err_count++;
            final_report();
        end
    end
    initial begin
        i = $urandom(32'hE786);
        repeat (12) @(posedge clock_i);
        @(negedge clock_i);
        reset_i = 1'b0;
        rd(8'h06, 8'h00);
        rd(8'h2A, 8'h00);
        wr(8'h06, 8'hFF);
        rd(8'h06, 8'h7F);
        wr(8'h06, 8'h05);
        rd(8'h06, 8'h7A);
        wr(8'h07, 8'hFF);
        rd(8'h07, 8'h3F);
        wr(8'h07, 8'h3E);
        rd(8'h07, 8'h01);
        ex = 8'h7A;
        for (i = 0; i < 8; i++) begin
            v = 8'($urandom);
            wr(8'h06, v);
            ex = v[7] ? (ex | {1'b0, v[6:0]}) : (ex & ~{1'b0, v[6:0]});
            rd(8'h06, ex);
        end
        wr(8'h07, 8'h01);
        wr(8'h06, 8'h7F);
        ce_i = 1'b0;
        wr(8'h06, 8'hFF);
        tick(1);
        ce_i = 1'b1;
        rd(8'h06, 8'h00);
        rd(8'h07, 8'h00);
        tick(1);
        $display("test registers ended");
        for (i = 0; i < 11; i++) begin
            pulse(11'h001 << i, 5'h00);
            rd(i < 6 ? 8'h07 : 8'h06, i < 6 ? 8'(8'h01 << i) : AMAP[i - 6]);
            wr(i < 6 ? 8'h07 : 8'h06, 8'h7F);
            tick(1);
        end
        for (i = 0; i < 5; i++) begin
            pulse(11'h000, 5'h01 << i);
            rd(8'h06, 8'h02);
            wr(8'h06, 8'h7F);
            tick(1);
        end
        // event and software clear on one edge: the event must win
        evt_i.rx_sof = 1'b1;
        wr(8'h06, 8'h01);
        evt_i.rx_sof = 1'b0;
        rd(8'h06, 8'h01);
        wr(8'h06, 8'h7F);
        tick(1);
        $display("test events ended");
        wr(8'h08, 8'h10);
        tick(1);
        cmd(1'b1, 4'h3, 1'b0);
        check({4'h0, command_o}, 8'h03);
        cmd(1'b0, 4'h3, 1'b1);
        check({4'h0, command_o}, 8'h00);
        tick(2);
        check({7'h00, global_request_o}, 8'h01);
        rd(8'h06, 8'h10);
        rd(8'h07, 8'h40);
        wr(8'h06, 8'h7F);
        tick(1);
        cmd(1'b1, 4'h5, 1'b0);
        cmd(1'b1, 4'h0, 1'b0);
        tick(3);
        rd(8'h06, 8'h00);
        rd(8'h07, 8'h00);
        tick(1);
        cmd(1'b1, 4'h7, 1'b0);
        tick(3);
        check({4'h0, command_o}, 8'h00);
        rd(8'h06, 8'h10);
        tick(1);
        $display("test commands ended");
        for (i = 0; i < 6; i++) begin
            wr(8'h08, PA[i]);
            wr(8'h09, PB[i]);
            tick(3);
            check({7'h00, line}, {7'h00, PL[i]});
        end
        wr(8'h08, 8'h06);
        wr(8'h09, 8'h01);
        tick(2);
        rd(8'h07, 8'h00);
        tick(1);
        pulse(11'h081, 5'h04);
        tick(2);
        rd(8'h06, 8'h16);
        rd(8'h07, 8'h41);
        wr(8'h06, 8'h7F);
        wr(8'h07, 8'h3F);
        tick(2);
        rd(8'h07, 8'h00);
        tick(2);
        $display("test pin and gating ended");
        final_report();
    end
endmodule

bind irqf_top irqf_props #(.CMD_KNOWN_MASK(CMD_KNOWN_MASK)) props (.*);
